// *** rx_event_status.sv ***
// Receive-event register, status shadow and frame-length readback.
`default_nettype none
module rx_event_status
    import rx_event_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        srst_i,
    input  wire logic        ce_i,
    input  wire logic        frame_done_i,
    input  wire logic        crc_ok_i,
    input  wire logic [10:0] frame_len_i,
    input  wire logic [2:0]  extra_bits_i,
    input  wire logic        hash_hit_i,
    input  wire logic [5:0]  hash_index_i,
    input  wire logic        station_hit_i,
    input  wire logic        all_ones_i,
    input  wire logic [15:0] receive_control_i,
    input  wire logic [15:0] receive_configuration_i,
    input  wire logic        rd_i,
    input  wire logic [11:0] addr_i,
    output logic      [15:0] rdata_o,
    output logic             rx_irq_o
);
    rx_event_if ev ();

    rx_event_classify u_cls (
        .mclk_i        (mclk_i),
        .srst_i        (srst_i),
        .ce_i          (ce_i),
        .done_i        (frame_done_i),
        .crc_ok_i      (crc_ok_i),
        .len_i         (frame_len_i),
        .extra_bits_i  (extra_bits_i),
        .hash_hit_i    (hash_hit_i),
        .hash_index_i  (hash_index_i),
        .station_hit_i (station_hit_i),
        .all_ones_i    (all_ones_i),
        .ctl_i         (receive_control_i),
        .ev            (ev)
    );

    // ======================================================================
    // Address decode
    // One compare serves every mapped offset, so the map lives in the package alone.
    function automatic logic hits(input logic [11:0] a, input logic [11:0] ofs);
        return a == ofs;
    endfunction
    wire rd_event_w  = rd_i && hits(addr_i, OFS_EVENT);
    wire rd_shadow_w = rd_i && hits(addr_i, OFS_SHADOW);
    wire rd_len_w    = rd_i && hits(addr_i, OFS_LENGTH);
    wire rd_any_w    = rd_event_w || rd_shadow_w || rd_len_w;

    // ======================================================================
    // Registers
    logic [15:0] event_q;
    logic [15:0] shadow_q;
    logic [10:0] length_q;
    logic [15:0] rdata_q;
    logic        irq_q;
    logic        crc_ok_q;
    logic        station_q;
    logic        all_ones_q;

    // ======================================================================
    // Interrupt causes
    wire        indexed_w = ev.flags[B_GOOD] && ev.flags[B_HASHED];
    wire [15:0] cfg_w     = receive_configuration_i;
    // An indexed word has no separate error bits, so only the good-frame cause applies.
    wire good_cause_w = ev.flags[B_GOOD] && cfg_w[CFG_GOOD_IE];
    wire crc_cause_w  = !indexed_w && ev.flags[B_BADCRC] && cfg_w[CFG_BADCRC_IE];
    wire runt_cause_w = !indexed_w && ev.flags[B_RUNT] && cfg_w[CFG_RUNT_IE];
    wire over_cause_w = !indexed_w && ev.flags[B_OVERSIZE] && cfg_w[CFG_OVER_IE];
    wire cause_w      = ev.valid && (good_cause_w || crc_cause_w || runt_cause_w || over_cause_w);

    // ======================================================================
    // Event and read path
    // A new frame wins over a read clear, so an event landing with the read is kept.
    wire [15:0] event_d  = ev.valid ? ev.flags
                         : (rd_event_w ? EVENT_RESET : event_q);
    wire [15:0] rd_mux_w = rd_event_w  ? event_q
                         : rd_shadow_w ? shadow_q
                         : rd_len_w    ? {5'h00, length_q}
                         : 16'h0000;

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            event_q  <= EVENT_RESET;
            shadow_q <= EVENT_RESET;
            length_q <= 11'h000;
            rdata_q  <= 16'h0000;
            irq_q    <= 1'b0;
        end else if (ce_i) begin
            event_q <= event_d;
            if (ev.valid) begin
                shadow_q <= ev.flags;
            end
            if (ev.valid && ev.flags[B_GOOD]) begin
                length_q <= ev.length;
            end
            rdata_q <= rd_mux_w;
            irq_q   <= cause_w;
        end
    end

    // Copies of the inputs at the capture edge, so the gating checks see what was decided.
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            crc_ok_q   <= 1'b0;
            station_q  <= 1'b0;
            all_ones_q <= 1'b0;
        end else if (ce_i) begin
            crc_ok_q   <= crc_ok_i;
            station_q  <= receive_control_i[CTL_STATION_A];
            all_ones_q <= receive_control_i[CTL_ALLONES_A];
        end
    end
    assign rdata_o  = rdata_q;
    assign rx_irq_o = irq_q;

    // ======================================================================
    // Assertions
    // The |=> checks look one edge after the cause, where the register has landed; the |-> checks look in the same cycle.
    a_event_id_fixed: assert property (@(posedge mclk_i) disable iff (srst_i)
        event_q[5:0] == EVENT_ID)
        else $error("event id lost");

    a_event_read_id: assert property (@(posedge mclk_i) disable iff (srst_i)
        ce_i && rd_event_w |=> rdata_o[5:0] == EVENT_ID)
        else $error("event id missing from read data");

    a_read_clears_event: assert property (@(posedge mclk_i) disable iff (srst_i)
        rd_event_w && ce_i && !ev.valid |=> event_q == EVENT_RESET)
        else $error("event not cleared by read");

    a_frame_wins_read: assert property (@(posedge mclk_i) disable iff (srst_i)
        ce_i && ev.valid |=> event_q == $past(ev.flags))
        else $error("frame flags not captured");

    a_event_read_data: assert property (@(posedge mclk_i) disable iff (srst_i)
        ce_i && rd_event_w |=> rdata_o == $past(event_q))
        else $error("event read data wrong");

    a_shadow_kept_read: assert property (@(posedge mclk_i) disable iff (srst_i)
        rd_event_w && !ev.valid |=> $stable(shadow_q))
        else $error("shadow changed");

    a_shadow_follows: assert property (@(posedge mclk_i) disable iff (srst_i)
        ce_i && ev.valid |=> shadow_q == $past(ev.flags))
        else $error("shadow missed frame");

    a_shadow_read_data: assert property (@(posedge mclk_i) disable iff (srst_i)
        ce_i && rd_shadow_w |=> rdata_o == $past(shadow_q))
        else $error("shadow read data wrong");

    a_good_needs_crc: assert property (@(posedge mclk_i) disable iff (srst_i)
        ev.valid && ev.flags[B_GOOD] |-> crc_ok_q)
        else $error("good without crc");

    a_length_good_lands: assert property (@(posedge mclk_i) disable iff (srst_i)
        ce_i && ev.valid && ev.flags[B_GOOD] |=> length_q == $past(ev.length))
        else $error("good frame length lost");

    a_length_good_only: assert property (@(posedge mclk_i) disable iff (srst_i)
        ce_i && !(ev.valid && ev.flags[B_GOOD]) |=> $stable(length_q))
        else $error("length changed without good frame");

    a_length_read_data: assert property (@(posedge mclk_i) disable iff (srst_i)
        ce_i && rd_len_w |=> rdata_o == {5'h00, $past(length_q)})
        else $error("length read data wrong");

    a_good_irq: assert property (@(posedge mclk_i) disable iff (srst_i)
        ce_i && ev.valid && ev.flags[B_GOOD] && cfg_w[CFG_GOOD_IE] |=> rx_irq_o)
        else $error("good frame irq missing");

    a_irq_needs_frame: assert property (@(posedge mclk_i) disable iff (srst_i)
        ce_i && !ev.valid |=> !rx_irq_o)
        else $error("irq without frame");

    a_ind_hash_cause: assert property (@(posedge mclk_i) disable iff (srst_i)
        ev.valid && ev.flags[B_IND_HASH] |-> ev.flags[B_HASHED])
        else $error("individual hash flag without hash hit");

    a_dribble_cause: assert property (@(posedge mclk_i) disable iff (srst_i)
        ce_i && frame_done_i && extra_bits_i != 3'h0 |=> ev.flags[B_DRIBBLE])
        else $error("dribble missed");

    a_index_carried: assert property (@(posedge mclk_i) disable iff (srst_i)
        ev.valid && indexed_w && ce_i |=> event_q[15:10] == $past(ev.flags[15:10]))
        else $error("hash index lost");

    a_badcrc_irq: assert property (@(posedge mclk_i) disable iff (srst_i)
        ce_i && ev.valid && !indexed_w && ev.flags[B_BADCRC] && cfg_w[CFG_BADCRC_IE]
        |=> rx_irq_o)
        else $error("bad checksum irq missing");

    a_runt_flagged: assert property (@(posedge mclk_i) disable iff (srst_i)
        ce_i && frame_done_i && frame_len_i < MIN_FRAME |=> !ev.flags[B_GOOD])
        else $error("runt marked good");

    a_runt_irq: assert property (@(posedge mclk_i) disable iff (srst_i)
        ce_i && ev.valid && !indexed_w && ev.flags[B_RUNT] && cfg_w[CFG_RUNT_IE]
        |=> rx_irq_o)
        else $error("runt irq missing");

    a_oversize_flagged: assert property (@(posedge mclk_i) disable iff (srst_i)
        ce_i && frame_done_i && frame_len_i > MAX_FRAME
        |=> ev.flags[B_OVERSIZE] && !ev.flags[B_GOOD])
        else $error("oversize not flagged");

    a_oversize_irq: assert property (@(posedge mclk_i) disable iff (srst_i)
        ce_i && ev.valid && !indexed_w && ev.flags[B_OVERSIZE] && cfg_w[CFG_OVER_IE]
        |=> rx_irq_o)
        else $error("oversize irq missing");

    a_station_gated: assert property (@(posedge mclk_i) disable iff (srst_i)
        ev.valid && !indexed_w && ev.flags[B_STATION] |-> station_q)
        else $error("station flag without accept");

    a_allones_gated: assert property (@(posedge mclk_i) disable iff (srst_i)
        ev.valid && !indexed_w && ev.flags[B_ALLONES] |-> all_ones_q)
        else $error("all ones flag without accept");

    a_idle_read_zero: assert property (@(posedge mclk_i) disable iff (srst_i)
        ce_i && !rd_any_w |=> rdata_o == 16'h0000)
        else $error("read data not zero without mapped read");

    a_hold_when_off: assert property (@(posedge mclk_i) disable iff (srst_i)
        !ce_i |=> $stable(event_q) && $stable(shadow_q) && $stable(rdata_o))
        else $error("state moved with clock enable low");
endmodule
`default_nettype wire

// *** rx_event_pkg.sv ***
// Package of constants for the receive-event status logic.
// Summary of operation
// - Event register reads id 000100 in low six bits; resets to 0x0004.
// - Individual-hash flag set only with hash hit and individual-hash accept enabled.
// - Dribble flag for one to seven extra bits; with bad checksum means misalignment.
// - Good frame needs good checksum, no runt, no oversize; length and interrupt follow.
// - Hash hit flag; with good frame, bits F..A carry the hash table index.
// - Every event flag clears when the host reads the event register with no new frame landing in that cycle.
// - Status shadow at 0400h mirrors events and is not cleared by event reads.
// - Event content is undefined while receive-via-DMA-always is set.
`default_nettype none
package rx_event_pkg;
    localparam logic [11:0] OFS_EVENT      = 12'h124;
    localparam logic [11:0] OFS_SHADOW     = 12'h400;
    localparam logic [11:0] OFS_LENGTH     = 12'h402;
    localparam logic [5:0]  EVENT_ID       = 6'h04;
    localparam logic [15:0] EVENT_RESET    = 16'h0004;
    localparam int          B_IND_HASH     = 6;
    localparam int          B_DRIBBLE      = 7;
    localparam int          B_GOOD         = 8;
    localparam int          B_HASHED       = 9;
    localparam int          B_STATION      = 10;
    localparam int          B_ALLONES      = 11;
    localparam int          B_BADCRC       = 12;
    localparam int          B_RUNT         = 13;
    localparam int          B_OVERSIZE     = 14;
    localparam int          CFG_GOOD_IE    = 8;
    localparam int          CFG_DMA_ONLY   = 9;
    localparam int          CFG_BADCRC_IE  = 12;
    localparam int          CFG_RUNT_IE    = 13;
    localparam int          CFG_OVER_IE    = 14;
    localparam int          CTL_IND_HASH_A = 6;
    localparam int          CTL_STATION_A  = 10;
    localparam int          CTL_ALLONES_A  = 11;
    localparam logic [10:0] MIN_FRAME      = 11'h040;
    localparam logic [10:0] MAX_FRAME      = 11'h5EE;
endpackage
`default_nettype wire

// *** rx_event_if.sv ***
// Interface carrying one classified frame into the event register.
`default_nettype none
interface rx_event_if;
    logic        valid;
    logic [15:0] flags;
    logic [10:0] length;
    modport src (output valid, output flags, output length);
    modport dst (input valid, input flags, input length);
endinterface
`default_nettype wire

// *** rx_event_classify.sv ***
// Classifier that turns end-of-frame facts into event flags.
`default_nettype none
module rx_event_classify
    import rx_event_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        srst_i,
    input  wire logic        ce_i,
    input  wire logic        done_i,
    input  wire logic        crc_ok_i,
    input  wire logic [10:0] len_i,
    input  wire logic [2:0]  extra_bits_i,
    input  wire logic        hash_hit_i,
    input  wire logic [5:0]  hash_index_i,
    input  wire logic        station_hit_i,
    input  wire logic        all_ones_i,
    input  wire logic [15:0] ctl_i,
    rx_event_if.src          ev
);
    wire runt_w  = len_i < MIN_FRAME;
    wire over_w  = len_i > MAX_FRAME;
    wire good_w  = crc_ok_i && !runt_w && !over_w;
    wire index_w = good_w && hash_hit_i;
    logic [15:0] f_w;
    always_comb begin
        f_w = EVENT_RESET;
        f_w[B_IND_HASH] = hash_hit_i && ctl_i[CTL_IND_HASH_A];
        f_w[B_DRIBBLE]  = extra_bits_i != 3'h0;
        f_w[B_GOOD]     = good_w;
        f_w[B_HASHED]   = hash_hit_i;
        if (index_w) begin
            f_w[15:10] = hash_index_i;
        end else begin
            f_w[B_STATION]  = station_hit_i && ctl_i[CTL_STATION_A];
            f_w[B_ALLONES]  = all_ones_i && ctl_i[CTL_ALLONES_A];
            f_w[B_BADCRC]   = !crc_ok_i;
            f_w[B_RUNT]     = runt_w;
            f_w[B_OVERSIZE] = over_w;
        end
    end
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            ev.valid  <= 1'b0;
            ev.flags  <= EVENT_RESET;
            ev.length <= 11'h000;
        end else if (ce_i) begin
            ev.valid  <= done_i;
            ev.flags  <= f_w;
            ev.length <= len_i;
        end
    end
endmodule
`default_nettype wire

// *** rx_host_model.sv ***
// Host model that reads the receive-event registers one strobe at a time.
`default_nettype none
module rx_host_model (
    input  wire logic        mclk_i,
    input  wire logic [15:0] rdata_i,
    output var  logic        rd_o,
    output var  logic [11:0] addr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        rd_o = 1'b0;
        addr_o = 12'h000;
    end
    // ==========================================
    // Read access
    // One read returns every event bit, so the caller must act on all of it.
    // Callers keep receive_via_dma_always low before trusting event content.
    task automatic read(input logic [11:0] a, output logic [15:0] v);
        @(posedge mclk_i);
        rd_o <= 1'b1;
        addr_o <= a;
        @(posedge mclk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        #1 v = rdata_i;
    endtask
endmodule
`default_nettype wire

// *** test_rx_frame_event_status.sv ***
// Self-checking testbench for the receive-event status block.
`default_nettype none
module test_rx_frame_event_status;
    import rx_event_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 1'b0, srst_i = 1'b1, done = 1'b0, crc = 1'b0, hit = 1'b0;
    logic sta = 1'b0, ones = 1'b0, rd, irq;
    logic ce = 1'b1;
    logic [10:0] len = 11'h000;
    logic [2:0] xb = 3'h0;
    logic [5:0] idx = 6'h00;
    logic [15:0] ctl = 16'h0000, cfg = 16'h0000, rdata, v;
    logic [11:0] addr;
    int num_errors = 0, comparisons = 0;
    initial forever #10 mclk_i = ~mclk_i;
    rx_host_model u_host (.mclk_i(mclk_i), .rdata_i(rdata), .rd_o(rd), .addr_o(addr));
    rx_event_status u_dut (.mclk_i(mclk_i), .srst_i(srst_i), .ce_i(ce),
        .frame_done_i(done), .crc_ok_i(crc), .frame_len_i(len), .extra_bits_i(xb),
        .hash_hit_i(hit), .hash_index_i(idx), .station_hit_i(sta), .all_ones_i(ones),
        .receive_control_i(ctl), .receive_configuration_i(cfg), .rd_i(rd),
        .addr_i(addr), .rdata_o(rdata), .rx_irq_o(irq));
    // ==========================================
    // Checking and closing
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [15:0] exp);
        u_host.read(a, v);
        check(v, exp);
    endtask
    // ==========================================
    // One frame, then irq, event, shadow and cleared event are checked.
    // The shadow read sits after the event read so a clearing shadow is caught.
    task automatic frame(input logic c, input logic [10:0] l, input logic [2:0] x,
        input logic h, input logic [5:0] i, input logic s, input logic o,
        input logic [15:0] ct, input logic [15:0] cf, input logic [15:0] ev, input logic q);
        @(posedge mclk_i);
        {done, crc, len, xb, hit, idx, sta, ones, ctl, cfg} <= {1'b1, c, l, x, h, i, s, o, ct, cf};
        @(posedge mclk_i);
        done <= 1'b0;
        @(posedge mclk_i);
        #1 check({15'h0000, irq}, {15'h0000, q});
        rd_chk(OFS_EVENT, ev);
        rd_chk(OFS_SHADOW, ev);
        rd_chk(OFS_EVENT, EVENT_RESET);
    endtask
    // ==========================================
    // Main sequence
    initial begin
        repeat (12) @(posedge mclk_i);
        srst_i <= 1'b0;
        rd_chk(OFS_EVENT, 16'h0004);
        rd_chk(OFS_SHADOW, 16'h0004);
        frame(1'b1, 11'h064, 3'h0, 1'b0, 6'h00, 1'b0, 1'b0, 16'h0000, 16'h0100, 16'h0104, 1'b1);
        rd_chk(OFS_LENGTH, 16'h0064);
        frame(1'b0, 11'h064, 3'h3, 1'b0, 6'h00, 1'b0, 1'b0, 16'h0000, 16'h1000, 16'h1084, 1'b1);
        frame(1'b1, 11'h03F, 3'h0, 1'b0, 6'h00, 1'b0, 1'b0, 16'h0000, 16'h2000, 16'h2004, 1'b1);
        frame(1'b1, 11'h5EF, 3'h0, 1'b0, 6'h00, 1'b0, 1'b0, 16'h0000, 16'h4000, 16'h4004, 1'b1);
        rd_chk(OFS_LENGTH, 16'h0064);
        frame(1'b1, 11'h064, 3'h0, 1'b1, 6'h2A, 1'b0, 1'b0, 16'h0040, 16'h0000, 16'hAB44, 1'b0);
        frame(1'b0, 11'h064, 3'h0, 1'b1, 6'h2A, 1'b0, 1'b0, 16'h0000, 16'h0000, 16'h1204, 1'b0);
        frame(1'b1, 11'h040, 3'h0, 1'b0, 6'h00, 1'b1, 1'b1, 16'h0C00, 16'h0000, 16'h0D04, 1'b0);
        frame(1'b1, 11'h5EE, 3'h0, 1'b0, 6'h00, 1'b1, 1'b1, 16'h0000, 16'h0100, 16'h0104, 1'b1);
        rd_chk(OFS_LENGTH, 16'h05EE);
        rd_chk(12'h126, 16'h0000);
        // A frame offered while the clock enable is low must leave no trace.
        @(posedge mclk_i);
        {ce, done} <= 2'b01;
        @(posedge mclk_i);
        {ce, done} <= 2'b10;
        rd_chk(OFS_EVENT, EVENT_RESET);
        // A good frame lands unread, then a reset in mid-run must wipe it.
        @(posedge mclk_i);
        {done, len} <= {1'b1, 11'h100};
        @(posedge mclk_i);
        done <= 1'b0;
        repeat (2) @(posedge mclk_i);
        srst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        srst_i <= 1'b0;
        rd_chk(OFS_EVENT, EVENT_RESET);
        rd_chk(OFS_SHADOW, EVENT_RESET);
        rd_chk(OFS_LENGTH, 16'h0000);
        conclude();
    end
endmodule
`default_nettype wire
